// ---- logic/pmfm_pkg.sv ----
// Contract
// - Preamble-skip set omits preamble; frame starts with start pattern.
// - Writing busy 1 launches one frame with programmed address, index, direction.
// - Busy clears itself when the frame completes.
// - Direction 0 selects read, 1 selects write.
// - Five-bit device address goes into frame PHY address field.
// - Five-bit register index goes into frame register field.
// - Divider codes 0..15 give MDC periods 4,6,8,...,54,60 clocks.
// - Order: preamble, 01, opcode, address, register, turnaround, 16 data, idle.
// - Opcode 10 for read, 01 for write.
// - Read turnaround releases line then PHY drives 0; write drives 1 then 0.
// - PHY drives read data, device captures; line released after data.
// - Clock-always-on set runs MDC continuously, else only during a command.
// - Data register supplies write data and receives captured read data.
package pmfm_pkg;
	localparam logic [3:0] OFS_DATA = 4'h0;
	localparam logic [3:0] OFS_CMD = 4'h4;
	localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
	localparam logic [3:0] OFS_IRQ_EN = 4'hc;
	// Write-only clear sits off the word grid; the address bus is only 4 bits
	localparam logic [3:0] OFS_IRQ_CLR = 4'h2;
	localparam int ADDR_W = 4;
	localparam int POS_DIV = 20;
	localparam int POS_CLKON = 19;
	localparam int POS_PRESKIP = 18;
	localparam int POS_BUSY = 17;
	localparam int POS_WRITE = 16;
	localparam int POS_TARGET_DEVICE_ADDR = 8;
	localparam int POS_REGIX = 0;
	localparam logic [31:0] CMD_RESET = 32'h0090_0000;
	localparam logic [15:0] DATA_RESET = 16'h0000;
	localparam int PREAMBLE_BITS = 32;
	localparam int DATA_BITS = 16;
	localparam int MDC_MIN_NS = 400;
	localparam int CLK_NS = 40;
	localparam int MDC_MIN_CYC = (MDC_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [1:0] START_PAT = 2'b01;
	localparam logic [1:0] OP_READ = 2'b10;
	localparam logic [1:0] OP_WRITE = 2'b01;

	// Full MDC period in clocks for each divider code
	function automatic logic [5:0] pmfm_period(input logic [3:0] code);
		logic [5:0] p;
		p = 6'h04;
		unique case (code)
			4'h0: p = 6'h04;
			4'h1: p = 6'h06;
			4'h2: p = 6'h08;
			4'h3: p = 6'h0c;
			4'h4: p = 6'h10;
			4'h5: p = 6'h14;
			4'h6: p = 6'h18;
			4'h7: p = 6'h1c;
			4'h8: p = 6'h1e;
			4'h9: p = 6'h20;
			4'ha: p = 6'h24;
			4'hb: p = 6'h28;
			4'hc: p = 6'h2c;
			4'hd: p = 6'h30;
			4'he: p = 6'h36;
			4'hf: p = 6'h3c;
		endcase
		return p;
	endfunction : pmfm_period
endpackage : pmfm_pkg

// ---- logic/pmfm_clk_if.sv ----
`timescale 1ns/1ps
interface pmfm_clk_if;
	logic [3:0] divCode;
	logic run;
	logic fallTick;
	logic riseTick;
	logic mdcLevel;
	modport gen (input divCode, input run, output fallTick, output riseTick,
		output mdcLevel);
	modport user (output divCode, output run, input fallTick, input riseTick,
		input mdcLevel);
endinterface : pmfm_clk_if

// ---- logic/pmfm_clk_gen.sv ----
`timescale 1ns/1ps
module pmfm_clk_gen
	import pmfm_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	pmfm_clk_if.gen ck
);
	logic [5:0] cnt;
	logic [5:0] half;

	always_comb
	begin
		half = pmfm_period(ck.divCode) >> 1;
	end

	// Stops low so a restart begins with a full low half
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt <= 6'h00;
			ck.mdcLevel <= 1'b0;
			ck.fallTick <= 1'b0;
			ck.riseTick <= 1'b0;
		end
		else if (!ck.run && !ck.mdcLevel)
		begin
			cnt <= 6'h00;
			ck.fallTick <= 1'b0;
			ck.riseTick <= 1'b0;
		end
		else if (cnt + 6'h01 >= half)
		begin
			cnt <= 6'h00;
			ck.mdcLevel <= !ck.mdcLevel;
			ck.riseTick <= !ck.mdcLevel;
			ck.fallTick <= ck.mdcLevel;
		end
		else
		begin
			cnt <= cnt + 6'h01;
			ck.fallTick <= 1'b0;
			ck.riseTick <= 1'b0;
		end
	end
endmodule : pmfm_clk_gen

// ---- logic/pmfm_shifter.sv ----
`timescale 1ns/1ps
module pmfm_shifter
	import pmfm_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	pmfm_clk_if.user ck,
	input wire logic start,
	input wire logic isWrite,
	input wire logic preSkip,
	input wire logic [4:0] phyAddr,
	input wire logic [4:0] regIdx,
	input wire logic [15:0] wrData,
	input wire logic mdioIn,
	output logic mdioOut,
	output logic mdioOe_n,
	output logic active,
	output logic done,
	output logic [15:0] rdData
);
	// 32 preamble + 32 frame bits; first bit is bit 63
	logic [63:0] shReg;
	logic [6:0] bitsLeft;
	logic readRelease;
	logic [6:0] frameBits;

	always_comb
	begin
		frameBits = preSkip ? 7'd32 : 7'd64;
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			shReg <= 64'h0;
			bitsLeft <= 7'h00;
			active <= 1'b0;
			done <= 1'b0;
			mdioOut <= 1'b1;
			mdioOe_n <= 1'b1;
			readRelease <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (start && !active)
			begin
				shReg <= {32'hffff_ffff, START_PAT,
					isWrite ? OP_WRITE : OP_READ, phyAddr, regIdx,
					2'b10, isWrite ? wrData : 16'h0};
				if (preSkip)
					shReg[63:32] <= {START_PAT, isWrite ? OP_WRITE : OP_READ,
						phyAddr, regIdx, 2'b10, isWrite ? wrData : 16'h0};
				bitsLeft <= frameBits;
				active <= 1'b1;
				readRelease <= !isWrite;
			end
			else if (active && ck.fallTick)
			begin
				if (bitsLeft == 7'h00)
				begin
					mdioOe_n <= 1'b1;
					active <= 1'b0;
					done <= 1'b1;
				end
				else
				begin
					mdioOut <= shReg[63];
					shReg <= {shReg[62:0], 1'b0};
					bitsLeft <= bitsLeft - 7'h01;
					// Read: release from turnaround onward
					mdioOe_n <= readRelease && bitsLeft <= 7'd18;
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			rdData <= DATA_RESET;
		else if (active && readRelease && ck.riseTick && bitsLeft < 7'd16)
			rdData <= {rdData[14:0], mdioIn};
	end
endmodule : pmfm_shifter

// ---- logic/pmfm_master.sv ----
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module pmfm_master
	import pmfm_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [pmfm_pkg::ADDR_W-1:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWritedata,
	input wire logic [3:0] avsByteenable,
	output logic [31:0] avsReaddata,
	output logic avsWaitrequest,
	output logic mdc,
	input wire logic mdioIn,
	output logic mdioOut,
	output logic mdioOe_n,
	output logic irq
);
	import pmfm_pkg::*;

	pmfm_clk_if ck();

	logic [3:0] divCode;
	logic clkOn;
	logic preSkip;
	logic busy;
	logic isWrite;
	logic [4:0] phyAddr;
	logic [4:0] regIdx;
	logic [15:0] dataWord;
	logic [1:0] irqStat;
	logic [1:0] irqEn;
	logic startReq;
	logic shActive;
	logic shDone;
	logic [15:0] shRd;
	logic mdoRaw;
	logic mdoeRaw;
	logic wrHit;
	logic rdHit;
	logic [31:0] cmdWord;

	assign ck.divCode = divCode;
	assign ck.run = clkOn || busy || shActive;

	pmfm_clk_gen u_clk (
		.mclk(mclk),
		.arst_n(arst_n),
		.ck(ck)
	);

	pmfm_shifter u_sh (
		.mclk(mclk),
		.arst_n(arst_n),
		.ck(ck),
		.start(startReq),
		.isWrite(isWrite),
		.preSkip(preSkip),
		.phyAddr(phyAddr),
		.regIdx(regIdx),
		.wrData(dataWord),
		.mdioIn(mdioIn),
		.mdioOut(mdoRaw),
		.mdioOe_n(mdoeRaw),
		.active(shActive),
		.done(shDone),
		.rdData(shRd)
	);

	// One wait cycle per access keeps read data registered
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			avsWaitrequest <= 1'b1;
		else
			avsWaitrequest <= !((avsRead || avsWrite) && avsWaitrequest);
	end
	assign wrHit = avsWrite && !avsWaitrequest;
	assign rdHit = avsRead && avsWaitrequest;

	assign cmdWord = {8'h00, divCode, clkOn, preSkip, busy, isWrite,
		3'h0, phyAddr, 3'h0, regIdx};

	// Command fields frozen while a frame runs
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			divCode <= CMD_RESET[POS_DIV+3:POS_DIV];
			clkOn <= CMD_RESET[POS_CLKON];
			preSkip <= CMD_RESET[POS_PRESKIP];
			isWrite <= CMD_RESET[POS_WRITE];
			phyAddr <= CMD_RESET[POS_TARGET_DEVICE_ADDR+4:POS_TARGET_DEVICE_ADDR];
			regIdx <= CMD_RESET[POS_REGIX+4:POS_REGIX];
		end
		else if (wrHit && avsAddress == OFS_CMD && !busy)
		begin
			if (avsByteenable[2])
			begin
				divCode <= avsWritedata[POS_DIV+3:POS_DIV];
				clkOn <= avsWritedata[POS_CLKON];
				preSkip <= avsWritedata[POS_PRESKIP];
				isWrite <= avsWritedata[POS_WRITE];
			end
			if (avsByteenable[1])
				phyAddr <= avsWritedata[POS_TARGET_DEVICE_ADDR+4:POS_TARGET_DEVICE_ADDR];
			if (avsByteenable[0])
				regIdx <= avsWritedata[POS_REGIX+4:POS_REGIX];
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			busy <= CMD_RESET[POS_BUSY];
			startReq <= 1'b0;
		end
		else
		begin
			startReq <= 1'b0;
			if (wrHit && avsAddress == OFS_CMD && avsByteenable[2]
				&& avsWritedata[POS_BUSY] && !busy)
			begin
				busy <= 1'b1;
				startReq <= 1'b1;
			end
			else if (shDone)
				busy <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			dataWord <= DATA_RESET;
		else if (shDone && !isWrite)
			dataWord <= shRd;
		else if (wrHit && avsAddress == OFS_DATA && !busy)
		begin
			if (avsByteenable[0])
				dataWord[7:0] <= avsWritedata[7:0];
			if (avsByteenable[1])
				dataWord[15:8] <= avsWritedata[15:8];
		end
	end

	// Bit 0 frame done, bit 1 busy write refused; set wins over clear
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			irqStat <= 2'b00;
			irqEn <= 2'b00;
		end
		else
		begin
			if (wrHit && avsAddress == OFS_IRQ_EN && avsByteenable[0])
				irqEn <= avsWritedata[1:0];
			irqStat <= (irqStat & ~((wrHit && avsAddress == OFS_IRQ_CLR
				&& avsByteenable[0]) ? avsWritedata[1:0] : 2'b00))
				| {wrHit && busy && (avsAddress == OFS_CMD
				|| avsAddress == OFS_DATA), shDone};
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			avsReaddata <= 32'h0;
			irq <= 1'b0;
			mdc <= 1'b0;
			mdioOut <= 1'b1;
			mdioOe_n <= 1'b1;
		end
		else
		begin
			irq <= |(irqStat & irqEn);
			mdc <= ck.mdcLevel;
			mdioOut <= mdoRaw;
			mdioOe_n <= mdoeRaw;
			if (rdHit)
			begin
				unique case (avsAddress)
					OFS_DATA: avsReaddata <= {16'h0, dataWord};
					OFS_CMD: avsReaddata <= cmdWord;
					OFS_IRQ_STAT: avsReaddata <= {30'h0, irqStat};
					OFS_IRQ_EN: avsReaddata <= {30'h0, irqEn};
					default: avsReaddata <= 32'h0;
				endcase
			end
		end
	end
endmodule : pmfm_master

// ---- sim/pmfm_monitor.sv ----
`timescale 1ns/1ps
module pmfm_monitor (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsReaddata,
	input wire logic avsWaitrequest,
	input wire logic mdc,
	input wire logic mdioOut,
	input wire logic mdioOe_n
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);
	a_read_ack: assert property ($rose(avsRead) |=> !avsWaitrequest)
		else $error("read ack late");
	a_write_ack: assert property ($rose(avsWrite) |=> !avsWaitrequest)
		else $error("write ack late");
	a_ack_pulse: assert property (!avsWaitrequest |=> avsWaitrequest)
		else $error("ack too long");
	a_rdata_hold: assert property (
		$changed(avsReaddata) |-> $past(avsRead))
		else $error("read data moved");
	a_mdc_high: assert property ($rose(mdc) |-> mdc[*2])
		else $error("mdc high too short");
	a_mdc_low: assert property ($fell(mdc) |-> (!mdc)[*2])
		else $error("mdc low too short");
	a_out_fall: assert property ($changed(mdioOut) |-> !mdc)
		else $error("data moved with mdc high");
	a_oe_fall: assert property ($changed(mdioOe_n) |-> !mdc)
		else $error("enable moved with mdc high");
endmodule : pmfm_monitor
bind pmfm_master pmfm_monitor u_mon (.mclk(mclk), .arst_n(arst_n),
	.avsRead(avsRead), .avsWrite(avsWrite), .avsReaddata(avsReaddata),
	.avsWaitrequest(avsWaitrequest), .mdc(mdc), .mdioOut(mdioOut),
	.mdioOe_n(mdioOe_n));

// ---- sim/pmfm_phy_model.sv ----
`timescale 1ns/1ps
module pmfm_phy_model (
	input wire logic mdc,
	input wire logic arst_n,
	input wire logic mdioOe_n,
	input wire logic line,
	input wire logic [15:0] rdWord,
	output logic phyEn,
	output logic phyBit,
	output logic [15:0] hdr,
	output logic [15:0] wd,
	output logic [7:0] nPre
);
	logic [5:0] cnt;
	logic [7:0] ones;
	logic rd;
	always @(posedge mdc or negedge arst_n)
		if (!arst_n)
		begin
			cnt <= 6'h0;
			ones <= 8'h0;
			rd <= 1'b0;
		end
		else if (cnt == 6'h0)
		begin
			if (!mdioOe_n && line)
				ones <= ones + 8'h1;
			else if (!mdioOe_n)
			begin
				nPre <= ones;
				ones <= 8'h0;
				hdr <= {hdr[14:0], line};
				cnt <= 6'h1;
			end
		end
		else
		begin
			if (cnt < 6'h10)
				hdr <= {hdr[14:0], line};
			else
				wd <= {wd[14:0], line};
			if (cnt == 6'h3)
				rd <= hdr[0] & !line;
			cnt <= (cnt == 6'h1f) ? 6'h0 : cnt + 6'h1;
		end
	// Change on falling mdc so the master samples settled data
	always @(negedge mdc or negedge arst_n)
		if (!arst_n)
			phyEn <= 1'b0;
		else
		begin
			phyEn <= rd && cnt >= 6'hf;
			phyBit <= cnt == 6'hf ? 1'b0 : rdWord[4'(6'h1f - cnt)];
		end
endmodule : pmfm_phy_model

// ---- sim/phy_management_frame_master_tb_top.sv ----
`timescale 1ns/1ps
module phy_management_frame_master_tb_top;
	import pmfm_pkg::*;
	localparam int TMO = 60000;
	localparam int PER[16] = '{4, 6, 8, 12, 16, 20, 24, 28, 30, 32, 36, 40,
		44, 48, 54, 60};
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic [3:0] avsAddress = 4'h0;
	logic avsRead = 1'b0;
	logic avsWrite = 1'b0;
	logic [31:0] avsWritedata = 32'h0;
	logic [15:0] rdWord = 16'h0;
	logic pm = 1'b0;
	logic [31:0] per = 32'h0;
	logic [31:0] avsReaddata, q;
	logic avsWaitrequest, mdc, mdioOut, mdioOe_n, irq, line, phyEn, phyBit;
	logic [15:0] hdr, wd;
	logic [7:0] nPre;
	int cyc = 0, nRise = 0, cycles = 0, n_fail = 0, total_checks = 0;
	always #20 mclk = ~mclk;
	// Released line floats to the pull-up
	assign line = !mdioOe_n ? mdioOut : phyEn ? phyBit : 1'b1;
	pmfm_master i_dut (.mclk(mclk), .arst_n(arst_n), .avsAddress(avsAddress),
		.avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
		.avsByteenable(4'hf), .avsReaddata(avsReaddata),
		.avsWaitrequest(avsWaitrequest), .mdc(mdc), .mdioIn(line),
		.mdioOut(mdioOut), .mdioOe_n(mdioOe_n), .irq(irq));
	pmfm_phy_model i_phy (.mdc(mdc), .arst_n(arst_n), .mdioOe_n(mdioOe_n),
		.line(line), .rdWord(rdWord), .phyEn(phyEn), .phyBit(phyBit),
		.hdr(hdr), .wd(wd), .nPre(nPre));
	task automatic results();
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic acc(input logic [3:0] a, input logic w, input logic [31:0] d);
		avsAddress <= a;
		avsWritedata <= d;
		avsWrite <= w;
		avsRead <= !w;
		do
			@(posedge mclk);
		while (avsWaitrequest !== 1'b0);
		q = avsReaddata;
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
		@(posedge mclk);
	endtask : acc
	task automatic poll();
		do
			acc(OFS_CMD, 1'b0, 32'h0);
		while (q[POS_BUSY] !== 1'b0);
	endtask : poll
	function automatic logic [31:0] cmd(input logic [3:0] d, input logic o,
		input logic p, input logic b, input logic w, input logic [9:0] a);
		return {8'h00, d, o, p, b, w, 3'h0, a[9:5], 3'h0, a[4:0]};
	endfunction : cmd
	task automatic t_frame(input logic w, input logic [3:0] d, input logic p,
		input logic [9:0] a, input logic [15:0] v);
		if (w)
			acc(OFS_DATA, 1'b1, {16'h0, v});
		rdWord <= v;
		acc(OFS_CMD, 1'b1, cmd(d, 1'b0, p, 1'b1, w, a));
		poll();
		chk(hdr, {2'b01, w ? OP_WRITE : OP_READ, a, 2'b10});
		chk(nPre, p ? 0 : PREAMBLE_BITS);
		chk(per, PER[d]);
		if (w)
			chk(wd, v);
		acc(OFS_DATA, 1'b0, 32'h0);
		chk(q, {16'h0, v});
		$display("frame test done");
	endtask : t_frame
	task automatic t_regs();
		int r0;
		acc(OFS_CMD, 1'b0, 32'h0);
		chk(q, CMD_RESET);
		acc(OFS_DATA, 1'b0, 32'h0);
		chk(q, {16'h0, DATA_RESET});
		acc(4'h2, 1'b0, 32'h0);
		chk(q, 32'h0);
		acc(OFS_CMD, 1'b1, cmd(4'h3, 1'b1, 1'b0, 1'b0, 1'b0, 10'h0));
		repeat (40) @(posedge mclk);
		chk(per, 12);
		acc(OFS_CMD, 1'b1, CMD_RESET);
		repeat (20) @(posedge mclk);
		r0 = nRise;
		repeat (100) @(posedge mclk);
		chk(nRise - r0, 0);
		$display("register test done");
	endtask : t_regs
	// Fast codes break the mdc minimum; the model tolerates them
	task automatic t_codes();
		for (int i = 0; i < 16; i++)
			t_frame(i[0], 4'(i), 1'b1, 10'(i * 37 + 5), 16'h1337 * 16'(i));
		$display("divider test done");
	endtask : t_codes
	task automatic t_irq();
		chk(irq, 1'b0);
		acc(OFS_IRQ_EN, 1'b1, 32'h3);
		repeat (2) @(posedge mclk);
		chk(irq, 1'b1);
		acc(OFS_CMD, 1'b1, cmd(4'h3, 1'b0, 1'b1, 1'b1, 1'b0, 10'h22));
		acc(OFS_CMD, 1'b1, cmd(4'h3, 1'b0, 1'b1, 1'b1, 1'b1, 10'h64));
		acc(OFS_IRQ_STAT, 1'b0, 32'h0);
		chk(q, 32'h3);
		poll();
		chk(hdr, {2'b01, OP_READ, 10'h22, 2'b10});
		acc(OFS_IRQ_CLR, 1'b1, 32'h3);
		repeat (2) @(posedge mclk);
		chk(irq, 1'b0);
		$display("interrupt test done");
	endtask : t_irq
	always @(posedge mclk)
	begin
		pm <= mdc;
		cycles <= cycles + 1;
		cyc <= (mdc && !pm) ? 1 : cyc + 1;
		if (mdc && !pm)
		begin
			per <= cyc;
			nRise <= nRise + 1;
		end
		if (cycles == TMO)
		begin
			n_fail++;
			results();
		end
	end
	initial
	begin
		repeat (20) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		t_regs();
		t_frame(1'b1, 4'h3, 1'b0, 10'h2aa, 16'ha5c3);
		t_frame(1'b0, 4'h4, 1'b0, 10'h155, 16'h5a3c);
		t_codes();
		t_irq();
		results();
	end
endmodule : phy_management_frame_master_tb_top
